// File: pkg/fcs_consts.svh
// Register map, field positions and timing constants of the flash control front end
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
`define FCS_ADDR_W          4
`define FCS_ADDR_RATIO      4'h0
`define FCS_ADDR_OPTION     4'h1
`define FCS_ADDR_CONFIG     4'h2
`define FCS_ADDR_STATUS     4'h3
`define FCS_ADDR_PROT       4'h4
`define FCS_BIT_LOADED      7
`define FCS_BIT_PRESCALE    6
`define FCS_BIT_UNLOCK_OK   7
`define FCS_BIT_RELOC_OFF   6
`define FCS_BIT_CODE_MODE   5
`define FCS_BIT_ACC_ERR     4
`define FCS_BIT_RATE_OK     1
`define FCS_BIT_UNSECURED   0
`define FCS_LOCK_OPEN       2'h2
`define FCS_KEY_BYTES       4'h8
`define FCS_PRESCALE_LAST   3'h7
`define FCS_ZERO8           8'h00
`define FCS_CLK_PERIOD_PS   25000
`define FCS_PULSE_MIN_NS    5000
`define FCS_PULSE_MAX_NS    6700
`endif

// File: pkg/fcs_pkg.sv
// Types shared by the flash control front end
package fcs_pkg;
   typedef enum logic [1:0] {
      FCS_KS_IDLE    = 2'b00,
      FCS_KS_COLLECT = 2'b01,
      FCS_KS_FAIL    = 2'b10
   } fcs_key_state_t;
endpackage : fcs_pkg

// File: core/fcs_flash_ctrl.sv
// Flash clock ratio, option copy and unlock code front end of the flash controller
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.svh"

//Contract
// [RULE1] Nine 8-bit control registers in register space (the code maps five, at addresses 0 to 4; other addresses read as zero)
// [RULE2] Reset copies stored option and protection bytes
// [RULE3] Ratio bits 6:0 readable, first write only
// [RULE4] Loaded flag cleared by reset, set by write
// [RULE5] Program and erase blocked until flag set
// [RULE6] Bit 6 selects bus clock or divided by 8
// [RULE7] Divide selected input by field plus one
// [RULE8] Software keeps flash clock in 150-200 kHz
// [RULE9] Timing pulse is one flash clock period
// [RULE10] Option changes only via reprogram and reset
// [RULE11] Allow bit 0 forbids any code unlock
// [RULE12] Only secured code writes count
// [RULE13] Eight ascending matching bytes unlock until reset
// [RULE14] Option bit 6 set disables vector relocation
// [RULE15] Lock field 1:0 unsecured, others secure
// [RULE16] Secure state blocks unsecured source memory access
// [RULE17] Match or full blank check opens lock field
// [RULE18] Config bit 5 routes key-area writes
// [RULE19] Software sets mode, writes eight, clears mode
// [RULE20] Early program or erase raises access error
// [RULE21] Later ratio writes leave contents unchanged
module fcs_flash_ctrl #(
   parameter int unsigned KEY_W = 64
) (
   // Clock and reset
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_in,
   // Register port
   input  wire logic [`FCS_ADDR_W-1:0] reg_addr_in,
   input  wire logic [7:0]             reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output logic      [7:0]             reg_rdata_out,
   // Flash array side
   input  wire logic [7:0]             stored_option_byte_in,
   input  wire logic [7:0]             stored_protection_byte_in,
   input  wire logic [KEY_W-1:0]       stored_unlock_code_in,
   input  wire logic                   blank_ok_in,
   // Key-area writes and command requests
   input  wire logic                   key_wr_in,
   input  wire logic [2:0]             key_idx_in,
   input  wire logic [7:0]             key_data_in,
   input  wire logic                   key_src_secure_in,
   input  wire logic                   pe_req_in,
   // Memory access screening
   input  wire logic                   access_src_unsecured_in,
   // Outputs to sequencer and system
   output logic                        pe_start_out,
   output logic                        access_error_flag_out,
   output logic                        flash_clk_tick_out,
   output logic                        secure_out,
   output logic                        access_block_out,
   output logic                        vector_relocation_off_out,
   output logic      [7:0]             protection_copy_out
);
   localparam int unsigned CLK_NS  = `FCS_CLK_PERIOD_PS / 1000;
   localparam int unsigned MIN_CYC = (`FCS_PULSE_MIN_NS * 1000 + `FCS_CLK_PERIOD_PS - 1)
                                     / `FCS_CLK_PERIOD_PS;
   localparam int unsigned MAX_CYC = `FCS_PULSE_MAX_NS / CLK_NS;

   // Lock field decode shared by the security flop and the blank check assertion
   function automatic logic lock_open(input logic [1:0] lock_f);
      return lock_f == `FCS_LOCK_OPEN;
   endfunction : lock_open

   logic [6:0]                 ratio_q;
   logic                       ratio_loaded_flag_q;
   logic [7:0]                 flash_option_copy_q;
   logic [7:0]                 protection_copy_q;
   logic                       unlock_code_write_mode_q;
   logic                       acc_err_q;
   logic [2:0]                 pre_cnt_q;
   logic [5:0]                 div_cnt_q;
   logic                       tick_q;
   logic                       pe_start_q;
   logic                       secure_q;
   logic                       block_q;
   logic [7:0]                 rdata_q;
   logic [3:0]                 key_cnt_q;
   fcs_pkg::fcs_key_state_t    ks_q;
   fcs_pkg::fcs_key_state_t    ks_d;

   // Decode
   wire wr_ratio  = reg_wr_in && (reg_addr_in == `FCS_ADDR_RATIO);
   wire wr_config = reg_wr_in && (reg_addr_in == `FCS_ADDR_CONFIG);
   wire wr_status = reg_wr_in && (reg_addr_in == `FCS_ADDR_STATUS);
   wire prescale  = ratio_q[`FCS_BIT_PRESCALE];
   wire [5:0] div_field = ratio_q[5:0];
   wire mode_set   = wr_config && reg_wdata_in[`FCS_BIT_CODE_MODE];
   wire mode_clear = wr_config && !reg_wdata_in[`FCS_BIT_CODE_MODE]
                     && unlock_code_write_mode_q;
   // Key-area writes start a command unless the code mode is on
   wire key_as_cmd = key_wr_in && !unlock_code_write_mode_q;                    // [RULE18]
   wire key_as_cmp = key_wr_in && unlock_code_write_mode_q;                     // [RULE18]
   wire pe_req     = pe_req_in || key_as_cmd;
   wire pe_ok      = pe_req && ratio_loaded_flag_q;                             // [RULE5]
   wire pe_reject  = pe_req && !ratio_loaded_flag_q;                            // [RULE20]
   wire [7:0] code_byte = stored_unlock_code_in[{key_idx_in, 3'b000} +: 8];
   // Debug-path writes never advance the match
   wire byte_good = key_src_secure_in && (key_idx_in == key_cnt_q[2:0])         // [RULE12]
                    && (key_data_in == code_byte) && (key_cnt_q < `FCS_KEY_BYTES);
   wire code_match = (ks_q == fcs_pkg::FCS_KS_COLLECT) && (key_cnt_q == `FCS_KEY_BYTES);
   wire unlock_now = mode_clear && code_match
                     && flash_option_copy_q[`FCS_BIT_UNLOCK_OK];                // [RULE11]
   wire open_lock  = unlock_now || blank_ok_in;                                 // [RULE17]
   wire pre_tick   = !prescale || (pre_cnt_q == `FCS_PRESCALE_LAST);            // [RULE6]
   wire div_wrap   = pre_tick && (div_cnt_q == div_field);                      // [RULE7]
   wire [9:0] period_w = 10'({4'h0, div_field} + 10'h001) << (prescale ? 3 : 0);
   // Range flag is advisory: software owns the rate, the sequencer does not check it
   wire rate_ok = (period_w >= 10'(MIN_CYC)) && (period_w <= 10'(MAX_CYC));
   wire [7:0] ratio_rd  = {ratio_loaded_flag_q, ratio_q};
   wire [7:0] config_rd = 8'(unlock_code_write_mode_q) << `FCS_BIT_CODE_MODE;
   wire [7:0] status_rd = (8'(acc_err_q) << `FCS_BIT_ACC_ERR)
                        | (8'(rate_ok) << `FCS_BIT_RATE_OK)
                        | (8'(!secure_q) << `FCS_BIT_UNSECURED);
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr_in)
         `FCS_ADDR_RATIO:  rd_mux = ratio_rd;                                   // [RULE3]
         `FCS_ADDR_OPTION: rd_mux = flash_option_copy_q;
         `FCS_ADDR_CONFIG: rd_mux = config_rd;
         `FCS_ADDR_STATUS: rd_mux = status_rd;
         `FCS_ADDR_PROT:   rd_mux = protection_copy_q;
         default:          rd_mux = `FCS_ZERO8;                                 // [RULE1]
      endcase
   end

   // Key sequence tracking
   always_comb begin
      ks_d = ks_q;
      case (ks_q)
         fcs_pkg::FCS_KS_IDLE: begin
            if (mode_set) ks_d = fcs_pkg::FCS_KS_COLLECT;
         end
         fcs_pkg::FCS_KS_COLLECT: begin
            if (mode_clear) ks_d = fcs_pkg::FCS_KS_IDLE;
            else if (key_as_cmp && !byte_good) ks_d = fcs_pkg::FCS_KS_FAIL;     // [RULE13]
         end
         // A failed round holds until the mode bit clears, so late good bytes cannot rescue it
         fcs_pkg::FCS_KS_FAIL: begin
            if (mode_clear) ks_d = fcs_pkg::FCS_KS_IDLE;
         end
         default: ks_d = fcs_pkg::FCS_KS_IDLE;
      endcase
   end

   // Stored bytes are sampled every cycle of the synchronous reset
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         flash_option_copy_q <= stored_option_byte_in;                          // [RULE2]
         protection_copy_q   <= stored_protection_byte_in;                      // [RULE2]
      end else if (open_lock) begin
         flash_option_copy_q[1:0] <= `FCS_LOCK_OPEN;                            // [RULE17]
      end
   end

   // Ratio register: first write wins, the rest fall away
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ratio_q             <= 7'h00;
         ratio_loaded_flag_q <= 1'b0;                                           // [RULE4]
      end else if (wr_ratio && !ratio_loaded_flag_q) begin
         ratio_q             <= reg_wdata_in[6:0];                              // [RULE3] [RULE21]
         ratio_loaded_flag_q <= 1'b1;                                           // [RULE4]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         unlock_code_write_mode_q <= 1'b0;
         ks_q                     <= fcs_pkg::FCS_KS_IDLE;
         key_cnt_q                <= 4'h0;
      end else begin
         if (wr_config) unlock_code_write_mode_q <= reg_wdata_in[`FCS_BIT_CODE_MODE];
         ks_q <= ks_d;
         if (mode_set && !unlock_code_write_mode_q) key_cnt_q <= 4'h0;
         else if (key_as_cmp && byte_good && ks_q == fcs_pkg::FCS_KS_COLLECT)
            key_cnt_q <= key_cnt_q + 4'h1;                                      // [RULE13]
      end
   end

   // Error flag: a new error in the clearing cycle survives
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         acc_err_q  <= 1'b0;
         pe_start_q <= 1'b0;
      end else begin
         if (pe_reject) acc_err_q <= 1'b1;                                      // [RULE20]
         else if (wr_status && reg_wdata_in[`FCS_BIT_ACC_ERR]) acc_err_q <= 1'b0;
         pe_start_q <= pe_ok;                                                   // [RULE5]
      end
   end

   // Divider idles until the ratio is loaded so no early pulse is seen
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !ratio_loaded_flag_q) begin
         pre_cnt_q <= 3'h0;
         div_cnt_q <= 6'h00;
         tick_q    <= 1'b0;
      end else begin
         pre_cnt_q <= prescale ? pre_cnt_q + 3'h1 : 3'h0;                       // [RULE6]
         if (pre_tick) div_cnt_q <= div_wrap ? 6'h00 : div_cnt_q + 6'h01;       // [RULE7]
         tick_q    <= div_wrap;                                                 // [RULE9]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         secure_q <= 1'b1;
         block_q  <= 1'b1;
         rdata_q  <= `FCS_ZERO8;
      end else begin
         secure_q <= !lock_open(flash_option_copy_q[1:0]);                       // [RULE15]
         block_q  <= secure_q && access_src_unsecured_in;                       // [RULE16]
         rdata_q  <= reg_rd_in ? rd_mux : `FCS_ZERO8;
      end
   end

   assign reg_rdata_out             = rdata_q;
   assign pe_start_out              = pe_start_q;
   assign access_error_flag_out     = acc_err_q;
   assign flash_clk_tick_out        = tick_q;
   assign secure_out                = secure_q;
   assign access_block_out          = block_q;
   assign vector_relocation_off_out = flash_option_copy_q[`FCS_BIT_RELOC_OFF];  // [RULE14]
   assign protection_copy_out       = protection_copy_q;

   // Checking helpers: since_q counts cycles from one tick to the next
   logic [9:0] since_q;
   logic       tick_seen_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         since_q     <= 10'h000;
         tick_seen_q <= 1'b0;
      end else begin
         since_q     <= tick_q ? 10'h001 : since_q + 10'h001;
         if (tick_q) tick_seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   chk_loaded_set: assert property (wr_ratio |=> ratio_loaded_flag_q) // [RULE4]
      else $error("loaded flag not set by ratio write");
   chk_ratio_frozen: assert property (ratio_loaded_flag_q |=> $stable(ratio_q)) // [RULE21]
      else $error("ratio changed after first write");
   chk_pe_blocked: assert property (pe_req && !ratio_loaded_flag_q // [RULE20]
      |=> !pe_start_out && access_error_flag_out)
      else $error("early program or erase not refused");
   chk_pe_allowed: assert property (pe_req && ratio_loaded_flag_q |=> pe_start_out) // [RULE5]
      else $error("permitted program or erase not started");
   chk_tick_period: assert property (flash_clk_tick_out && tick_seen_q && !$past(tick_q) // [RULE7]
      |-> since_q == period_w)
      else $error("flash clock period wrong");
   chk_no_backdoor_unlock_allow: assert property (!flash_option_copy_q[`FCS_BIT_UNLOCK_OK] && !blank_ok_in // [RULE11]
      |=> $stable(flash_option_copy_q[1:0]))
      else $error("lock field moved without allow bit");
   chk_debug_no_effect: assert property (key_as_cmp && !key_src_secure_in // [RULE12]
      && ks_q == fcs_pkg::FCS_KS_COLLECT |=> ks_q == fcs_pkg::FCS_KS_FAIL)
      else $error("debug code write accepted");
   chk_unlock_match: assert property (unlock_now |=> ##1 !secure_out) // [RULE13]
      else $error("matching code did not unlock");
   chk_blank_unsec: assert property (blank_ok_in |=> lock_open(flash_option_copy_q[1:0])) // [RULE17]
      else $error("blank check did not open lock field");
   chk_secure_decode: assert property (1'b1 // [RULE15]
      |=> secure_out == ($past(flash_option_copy_q[1:0]) != `FCS_LOCK_OPEN))
      else $error("security decode wrong");
   chk_access_block: assert property (secure_out && access_src_unsecured_in // [RULE16]
      |=> access_block_out)
      else $error("unsecured access not blocked");
   chk_key_route: assert property (key_as_cmp && !pe_req_in |=> !pe_start_out) // [RULE18]
      else $error("code write started a command");

   // Reset load is checked at the first edge out of reset, where the guard is off
   chk_option_load: assert property ($fell(rst_in) |-> flash_option_copy_q == // [RULE2]
      $past(stored_option_byte_in) && protection_copy_q == $past(stored_protection_byte_in))
      else $error("option or protection copy not loaded at reset");
   chk_err_clear: assert property (wr_status && reg_wdata_in[`FCS_BIT_ACC_ERR] // [RULE20]
      && !pe_reject |=> !access_error_flag_out)
      else $error("access error not cleared by status write");
   chk_tick_idle: assert property (!ratio_loaded_flag_q |=> !flash_clk_tick_out) // [RULE5]
      else $error("flash clock ran before ratio loaded");
   chk_ratio_first: assert property (wr_ratio && !ratio_loaded_flag_q // [RULE3]
      |=> ratio_q == $past(reg_wdata_in[6:0]))
      else $error("first ratio write not taken");
   chk_block_open: assert property (!secure_out |=> !access_block_out) // [RULE16]
      else $error("access blocked while unsecured");
   chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == `FCS_ZERO8) // [RULE1]
      else $error("read data shown without a read");

   cov_unlock:   cover property (unlock_now ##2 !secure_out);
   cov_pe_start: cover property (wr_ratio ##[1:20] pe_start_out);
   cov_acc_err:  cover property (pe_reject ##1 access_error_flag_out);
   cov_tick:     cover property (flash_clk_tick_out ##[1:600] flash_clk_tick_out);
   cov_blank:    cover property (blank_ok_in ##2 !secure_out);
endmodule : fcs_flash_ctrl
`default_nettype wire

// File: test/fcs_flash_model.sv
// Flash array model: stored option, protection and unlock code bytes
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
   parameter logic [63:0] CODE = 64'h0123456789ABCDEF
) (
   // Clock and stimulus
   input  wire logic        clk_sys_in,
   input  wire logic        reprog_in,
   input  wire logic [7:0]  new_option_in,
   input  wire logic        blank_req_in,
   // Stored contents seen by the controller
   output logic      [7:0]  option_out,
   output logic      [7:0]  prot_out,
   output logic      [63:0] code_out,
   output logic             blank_ok_out
);
   // The stored byte only changes by reprogramming; the copy follows at the next reset
   always_ff @(posedge clk_sys_in) begin
      if (reprog_in) begin
         option_out <= new_option_in;
      end
      blank_ok_out <= blank_req_in;
   end
   assign prot_out = 8'hF8;
   assign code_out = CODE;
endmodule : fcs_flash_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the flash control front end
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.svh"
module tb_top;
   localparam logic [63:0] CODE = 64'h0123456789ABCDEF;
   localparam logic [3:0]  A_RAT = `FCS_ADDR_RATIO;
   localparam logic [3:0]  A_OPT = `FCS_ADDR_OPTION;
   localparam logic [3:0]  A_CFG = `FCS_ADDR_CONFIG;
   localparam logic [3:0]  A_STA = `FCS_ADDR_STATUS;
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        key_wr = 1'b0;
   logic        src_sec = 1'b1;
   logic        pe_req = 1'b0;
   logic        reprog = 1'b0;
   logic        blank_req = 1'b0;
   logic        unsec_src = 1'b0;
   logic [2:0]  key_idx = 3'h0;
   logic [7:0]  key_data = 8'h00;
   logic [7:0]  new_opt = 8'h00;
   logic [7:0]  rdata, opt_b, prot_b, prot_cp;
   logic [63:0] code;
   logic        blank_ok, pe_start, acc_err, tick, secure, blk, reloc_off;
   int          err_total = 0;
   int          checks_done = 0;
   int          n;
   always #12.5 clk_sys_in = ~clk_sys_in;
   fcs_flash_model #(.CODE(CODE)) model_u (.clk_sys_in(clk_sys_in), .reprog_in(reprog),
      .new_option_in(new_opt), .blank_req_in(blank_req), .option_out(opt_b),
      .prot_out(prot_b), .code_out(code), .blank_ok_out(blank_ok));
   fcs_flash_ctrl #(.KEY_W(64)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .stored_option_byte_in(opt_b),
      .stored_protection_byte_in(prot_b), .stored_unlock_code_in(code),
      .blank_ok_in(blank_ok), .key_wr_in(key_wr), .key_idx_in(key_idx),
      .key_data_in(key_data), .key_src_secure_in(src_sec), .pe_req_in(pe_req),
      .access_src_unsecured_in(unsec_src), .pe_start_out(pe_start),
      .access_error_flag_out(acc_err), .flash_clk_tick_out(tick), .secure_out(secure),
      .access_block_out(blk), .vector_relocation_off_out(reloc_off),
      .protection_copy_out(prot_cp));
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chkb(input string what, input logic exp, input logic got);
      chk(what, {7'h00, exp}, {7'h00, got});
   endtask : chkb
   // Register and key strobes are followed by an idle edge so no signal is assigned twice in one step; pulse_req only waits 1 ns
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 chk(what, exp, rdata);
      @(posedge clk_sys_in);
   endtask : rd_reg
   task automatic pulse_req();
      pe_req <= 1'b1;
      @(posedge clk_sys_in);
      pe_req <= 1'b0;
      #1;
   endtask : pulse_req
   task automatic key_byte(input int i, input logic [7:0] d, input logic s);
      key_idx <= i[2:0];
      key_data <= d;
      src_sec <= s;
      key_wr <= 1'b1;
      @(posedge clk_sys_in);
      key_wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask : key_byte
   // Bad selects one corrupted byte; 8 sends the stored code unchanged
   task automatic unlock(input int bad, input logic s, input logic exp);
      wr_reg(A_CFG, 8'h20);
      rd_reg(A_CFG, 8'h20, "config mode");
      for (int i = 0; i < 8; i++) begin
         key_byte(i, CODE[8*i +: 8] ^ ((i == bad) ? 8'h01 : 8'h00), s);
      end
      wr_reg(A_CFG, 8'h00);
      repeat (2) @(posedge clk_sys_in);
      #1 chkb("secure after code", exp, secure);
   endtask : unlock
   task automatic wait_tick();
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1 n++;
      end while (tick !== 1'b1 && n < 500);
      if (n >= 500) begin
         err_total++;
         results();
      end
   endtask : wait_tick
   task automatic do_reset(input logic [7:0] opt);
      new_opt <= opt;
      reprog <= 1'b1;
      rst_in <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      reprog <= 1'b0;
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : do_reset
   initial begin
      do_reset(8'h01);
      rd_reg(A_OPT, 8'h01, "option copy");
      rd_reg(`FCS_ADDR_PROT, 8'hF8, "protection copy");
      chk("protection port", 8'hF8, prot_cp);
      rd_reg(A_RAT, 8'h00, "ratio at reset");
      rd_reg(4'h7, 8'h00, "unmapped read");
      chkb("secure lock 01", 1'b1, secure);
      chkb("relocation off", 1'b0, reloc_off);
      unsec_src <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 chkb("access block", 1'b1, blk);
      pulse_req();
      chkb("early start", 1'b0, pe_start);
      chkb("early error", 1'b1, acc_err);
      wr_reg(A_STA, 8'h10);
      chkb("error cleared", 1'b0, acc_err);
      key_byte(0, 8'h00, 1'b1);
      chkb("key area command error", 1'b1, acc_err);
      wr_reg(A_STA, 8'h10);
      $display("test reset and refusal done");
      wr_reg(A_RAT, 8'h58);
      rd_reg(A_RAT, 8'hD8, "ratio loaded");
      wr_reg(A_RAT, 8'h05);
      rd_reg(A_RAT, 8'hD8, "ratio second write");
      wr_reg(A_OPT, 8'hFF);
      rd_reg(A_OPT, 8'h01, "option write");
      rd_reg(A_STA, 8'h02, "status rate");
      wait_tick();
      wait_tick();
      chk("tick period", 8'hC8, n[7:0]);
      pulse_req();
      chkb("start when loaded", 1'b1, pe_start);
      chkb("no error when loaded", 1'b0, acc_err);
      $display("test clock ratio done");
      unlock(8, 1'b1, 1'b1);
      blank_req <= 1'b1;
      @(posedge clk_sys_in);
      blank_req <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1 chkb("secure after blank", 1'b0, secure);
      chkb("access open", 1'b0, blk);
      rd_reg(A_OPT, 8'h02, "option after blank");
      rd_reg(A_STA, 8'h03, "status unsecured");
      do_reset(8'hC3);
      rd_reg(A_OPT, 8'hC3, "option reloaded");
      rd_reg(A_RAT, 8'h00, "ratio after reset");
      chkb("secure lock 11", 1'b1, secure);
      chkb("relocation off set", 1'b1, reloc_off);
      unlock(8, 1'b0, 1'b1);
      unlock(3, 1'b1, 1'b1);
      unlock(8, 1'b1, 1'b0);
      rd_reg(A_OPT, 8'hC2, "option after code");
      $display("test unlock done");
      results();
   end
endmodule : tb_top
`default_nettype wire
